// *** verilog/pdt_pkg.sv ***
// Shared constants for the prescaled down-counter timer
package pdt_pkg;

   // Data-space locations of the timer registers
   localparam logic [7:0] ADDR_PRESCALER = 8'h00D2;
   localparam logic [7:0] ADDR_COUNT     = 8'h00D3;
   localparam logic [7:0] ADDR_CONTROL   = 8'h00D4;

   // Values after reset
   localparam logic [7:0] RESET_COUNT     = 8'h00FF;
   localparam logic [6:0] RESET_PRESCALER = 7'h7F;
   localparam logic [7:0] RESET_CONTROL   = 8'h0000;

   // Prescaler value forced while the run bit is low
   localparam logic [6:0] PRESCALER_IDLE = 7'h7F;

   // Field positions in timer_control_status
   localparam int BIT_ZERO_FLAG   = 7;
   localparam int BIT_IRQ_ENABLE  = 6;
   localparam int BIT_RESERVED    = 5;
   localparam int BIT_UNUSED      = 4;
   localparam int BIT_RUN         = 3;
   localparam int BIT_TAP_HI      = 2;
   localparam int BIT_TAP_LO      = 0;

   // Internal clock is divided by this before the prescaler
   localparam int          PRE_DIVIDE      = 12;
   localparam logic [3:0]  PRE_DIVIDE_LAST = 4'(PRE_DIVIDE - 1);

   // Interrupt vector number served by this timer
   localparam logic [2:0] IRQ_VECTOR = 3'h4;

   // Value that sets the zero flag when written to the counter
   localparam logic [7:0] COUNT_ZERO = 8'h0000;

endpackage

// *** verilog/pdt_timer.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1: 8-bit counter decrements on tap edge, loadable.
// R2: Interrupt request when zero flag and enable.
// R3: Zero flag set on decrement to zero.
// R4: Prescaler clocked by internal clock over 12.
// R5: Division 1 uses prescaler input; else bit.
// R6: Tap select encodings 0..7 divide 1..128.
// R7: Run bit low holds prescaler 7Fh, stops.
// R8: Prescaler writable only while run bit high.
// R9: Writing 00h count or control bit7 sets flag.
// R10: Software clears zero flag; hardware never does.
// R11: Reset: count FFh, prescaler 7Fh, control 00h.
// R12: Count write beats decrement to zero.
// R13: Count and prescaler readable at any time.
// R14: Prescaler reads zero in top bit.
// R15: Software writes one to reserved bit 5.
// R16: Interrupt request can wake processor from wait.
// R17: Counter wraps past zero; flag stays set.
module pdt_timer
(
   input  wire logic       clk,        // Internal clock, 25 MHz
   input  wire logic       rst,        // Asynchronous reset, active high
   input  wire logic [7:0] addr,       // Data-space address
   input  wire logic       wr_en,      // Write strobe, one cycle
   input  wire logic [7:0] wdata,      // Write data
   input  wire logic       rd_en,      // Read strobe, one cycle
   output logic      [7:0] rdata,      // Read data, valid cycle after rd_en
   output logic            irq_req,    // Timer interrupt request, level
   output logic      [2:0] irq_vector  // Vector number of the request
);

   // Prescaler tap bit selected by a nonzero tap code
   // Division 1 never comes here; the caller takes the tick directly
   function automatic logic tap_bit(input logic [6:0] value,
                                    input logic [2:0] sel);
      logic [2:0] idx;
      idx = sel - 3'h1;
      tap_bit = value[idx];
   endfunction

   // Register address match, shared by the three write decoders
   function automatic logic addr_is(input logic [7:0] where,
                                    input logic [7:0] reg_addr);
      addr_is = (where == reg_addr);
   endfunction

   // Decoded register strokes
   logic wr_prescaler;
   logic wr_count;
   logic wr_control;

   // Writes to unmapped locations fall through every decode and vanish
   assign wr_prescaler = wr_en && addr_is(addr, pdt_pkg::ADDR_PRESCALER);
   assign wr_count     = wr_en && addr_is(addr, pdt_pkg::ADDR_COUNT);
   assign wr_control   = wr_en && addr_is(addr, pdt_pkg::ADDR_CONTROL);

   // Control fields; the reserved and unused bits are stored so that a read
   // gives back what software last wrote there
   logic       zero_flag;
   logic       irq_enable;
   logic       reserved_one_bit;
   logic       unused_bit;
   logic       prescaler_run;
   logic [2:0] tap_select;
   logic       next_zero_flag;
   logic       next_irq_enable;
   logic       next_reserved_one_bit;
   logic       next_unused_bit;
   logic       next_prescaler_run;
   logic [2:0] next_tap_select;

   // Timing chain: the divider counts 0..11, the prescaler holds seven bits
   // and the counter eight
   logic [3:0] div_count;
   logic [6:0] prescaler_value;
   logic [7:0] timer_count;
   logic [3:0] next_div_count;
   logic [6:0] next_prescaler_value;
   logic [7:0] next_timer_count;

   // Next values of the output flip-flops; the pins themselves never see
   // combinational logic
   logic [7:0] next_rdata;
   logic       next_irq_req;

   // Internal events; pre_tick lasts one clock in twelve and count_tick
   // is never high without it
   logic       pre_tick;
   logic [6:0] pre_after_tick;
   logic       count_tick;
   logic       dec_to_zero;

   // The whole timing chain runs on clk. While the run bit is set the
   // divider turns every twelfth clock into a one-cycle tick, and each
   // tick steps the prescaler down by one. The counter steps on the tick
   // itself for division 1, otherwise on a rising edge of the chosen
   // prescaler bit. No bit of the chain is ever used as a clock, which
   // keeps the block in one timing domain at the cost of comparators.
   // Divide-by-12 stage and prescaler tick
   always_comb
   begin
      next_div_count = div_count;
      pre_tick       = 1'b0;
      if (prescaler_run)
      begin
         if (div_count == pdt_pkg::PRE_DIVIDE_LAST)
         begin
            next_div_count = 4'h0;
            pre_tick       = 1'b1;                     // see R4
         end
         else
         begin
            next_div_count = div_count + 4'h1;
         end
      end
      else
      begin
         // Restart the divider so a fresh run has a known phase: the first
         // tick comes twelve clocks after the run bit is written
         next_div_count = 4'h0;
      end
   end

   // Prescaler and counter clock taps; edges are found by comparing the
   // tapped bit before and after the tick, so no derived clock exists
   always_comb
   begin
      pre_after_tick = prescaler_value - 7'h01;        // see R4
      count_tick     = 1'b0;
      // A prescaler write in the tick cycle replaces the step, so the
      // counter must not follow an edge that the prescaler never made
      if (pre_tick && !wr_prescaler)
      begin
         if (tap_select == 3'h0)
         begin
            count_tick = 1'b1;                         // see R5
         end
         else
         begin
            count_tick = !tap_bit(prescaler_value, tap_select) &&
                         tap_bit(pre_after_tick, tap_select); // see R6
         end
      end
   end

   // Prescaler next value
   always_comb
   begin
      next_prescaler_value = prescaler_value;
      // Follow the run bit as it is being written, so a stop forces 7Fh on
      // the same edge and a read never sees a stale value after the stop
      if (!next_prescaler_run)
      begin
         next_prescaler_value = pdt_pkg::PRESCALER_IDLE; // see R7
      end
      else if (wr_prescaler)
      begin
         next_prescaler_value = wdata[6:0];            // see R8
      end
      else if (pre_tick)
      begin
         next_prescaler_value = pre_after_tick;
      end
   end

   // Counter next value; a write takes precedence over counting
   always_comb
   begin
      next_timer_count = timer_count;
      dec_to_zero      = 1'b0;
      if (wr_count)
      begin
         next_timer_count = wdata;                     // see R1 R12
      end
      // A load beats a step in the same cycle, so a step to 00h that loses
      // to a write leaves the flag alone; only a written 00h sets it
      else if (count_tick && next_prescaler_run)
      begin
         // Wraps from 00h to FFh and keeps counting
         next_timer_count = timer_count - 8'h01;       // see R1 R17
         dec_to_zero      = (timer_count == 8'h01);    // see R3
      end
   end

   // Control and status next values; a hardware set beats a software clear
   always_comb
   begin
      next_zero_flag        = zero_flag;
      next_irq_enable       = irq_enable;
      next_reserved_one_bit = reserved_one_bit;
      next_unused_bit       = unused_bit;
      next_prescaler_run    = prescaler_run;
      next_tap_select       = tap_select;
      if (wr_control)
      begin
         // Besides reset, writing 0 is the only way the flag clears
         next_zero_flag        = wdata[pdt_pkg::BIT_ZERO_FLAG]; // see R9 R10
         next_irq_enable       = wdata[pdt_pkg::BIT_IRQ_ENABLE];
         next_reserved_one_bit = wdata[pdt_pkg::BIT_RESERVED];  // see R15
         next_unused_bit       = wdata[pdt_pkg::BIT_UNUSED];
         next_prescaler_run    = wdata[pdt_pkg::BIT_RUN];       // see R7
         next_tap_select       =
            wdata[pdt_pkg::BIT_TAP_HI:pdt_pkg::BIT_TAP_LO];     // see R6
      end
      // Hardware sets come last, so a clear written in the cycle of a step
      // to zero loses; software should read the flag back after clearing
      if (dec_to_zero)
      begin
         next_zero_flag = 1'b1;                        // see R3
      end
      if (wr_count && (wdata == pdt_pkg::COUNT_ZERO))
      begin
         next_zero_flag = 1'b1;                        // see R9
      end
   end

   // Request follows flag and enable; also serves as wait-mode wake-up.
   // It is a level, not a pulse: it stays up until software clears the
   // flag or the enable, so a request missed during a wait is not lost
   always_comb
   begin
      next_irq_req = next_zero_flag && next_irq_enable; // see R2 R16
   end

   // Read data; reads have no side effects. The mux looks at the registers,
   // so a read in the cycle of a write returns the old value, and an
   // unmapped location reads as 00h
   always_comb
   begin
      next_rdata = rdata;
      if (rd_en)
      begin
         case (addr)
            pdt_pkg::ADDR_PRESCALER:
               next_rdata = {1'b0, prescaler_value};   // see R13 R14
            pdt_pkg::ADDR_COUNT:
               next_rdata = timer_count;               // see R13
            pdt_pkg::ADDR_CONTROL:
               next_rdata = {zero_flag, irq_enable, reserved_one_bit,
                             unused_bit, prescaler_run, tap_select};
            default:
               next_rdata = 8'h0000;
         endcase
      end
   end

   // Register stage for the timing chain; reset leaves the timer stopped
   // with the counter at its top value
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         div_count       <= 4'h0;
         prescaler_value <= pdt_pkg::RESET_PRESCALER;  // see R11
         timer_count     <= pdt_pkg::RESET_COUNT;      // see R11
      end
      else
      begin
         div_count       <= next_div_count;
         prescaler_value <= next_prescaler_value;
         timer_count     <= next_timer_count;
      end
   end

   // Register stage for control and status
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         zero_flag        <= pdt_pkg::RESET_CONTROL[pdt_pkg::BIT_ZERO_FLAG];
         irq_enable       <= pdt_pkg::RESET_CONTROL[pdt_pkg::BIT_IRQ_ENABLE];
         reserved_one_bit <= pdt_pkg::RESET_CONTROL[pdt_pkg::BIT_RESERVED];
         unused_bit       <= pdt_pkg::RESET_CONTROL[pdt_pkg::BIT_UNUSED];
         prescaler_run    <= pdt_pkg::RESET_CONTROL[pdt_pkg::BIT_RUN];
         tap_select       <=                           // see R11
            pdt_pkg::RESET_CONTROL[pdt_pkg::BIT_TAP_HI:pdt_pkg::BIT_TAP_LO];
      end
      else
      begin
         zero_flag        <= next_zero_flag;
         irq_enable       <= next_irq_enable;
         reserved_one_bit <= next_reserved_one_bit;
         unused_bit       <= next_unused_bit;
         prescaler_run    <= next_prescaler_run;
         tap_select       <= next_tap_select;
      end
   end

   // Output register stage; every pin comes straight from a flip-flop, so
   // read data lags its strobe by one cycle and never glitches
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata      <= 8'h0000;
         irq_req    <= 1'b0;
         irq_vector <= pdt_pkg::IRQ_VECTOR;
      end
      else
      begin
         rdata      <= next_rdata;
         irq_req    <= next_irq_req;                   // see R2 R16
         irq_vector <= pdt_pkg::IRQ_VECTOR;            // see R2
      end
   end

endmodule // pdt_timer

// *** dv/pdt_timer_chk.sv ***
`timescale 1ns/1ps
// Port-level checks on the timer; only the top module's pins are visible
module pdt_timer_chk
(
   input wire logic       clk,        // Internal clock
   input wire logic       rst,        // Async reset, active high
   input wire logic [7:0] addr,       // Data-space address
   input wire logic       wr_en,      // Write strobe
   input wire logic [7:0] wdata,      // Write data
   input wire logic       rd_en,      // Read strobe
   input wire logic [7:0] rdata,      // Read data
   input wire logic       irq_req,    // Interrupt request
   input wire logic [2:0] irq_vector  // Vector number
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Software reaches flag and enable through control writes; a count write of 00h also sets the flag
   vec_fixed_a: assert property (
      irq_vector == pdt_pkg::IRQ_VECTOR) else $error("vector wrong");
   en_raise_a: assert property (
      wr_en && addr == pdt_pkg::ADDR_CONTROL && wdata[7] && wdata[6]
      |=> irq_req) else $error("request not raised");
   en_drop_a: assert property (
      wr_en && addr == pdt_pkg::ADDR_CONTROL && !wdata[6]
      |=> !irq_req) else $error("request while disabled");
   psc_top_a: assert property (
      rd_en && addr == pdt_pkg::ADDR_PRESCALER |=> !rdata[7])
      else $error("prescaler top bit set");
   zero_wr_a: assert property (
      (wr_en && addr == pdt_pkg::ADDR_CONTROL && wdata[6]) ##1
      !(wr_en && addr == pdt_pkg::ADDR_CONTROL) ##1
      (wr_en && addr == pdt_pkg::ADDR_COUNT && wdata == 8'h00)
      |=> irq_req) else $error("zero write did not flag");
   rd_hold_a: assert property (
      !rd_en |=> $stable(rdata)) else $error("read data moved");
   irq_fall_a: assert property (
      $fell(irq_req) |-> $past(wr_en)
      && $past(addr) == pdt_pkg::ADDR_CONTROL)
      else $error("request dropped by itself");
   irq_keep_a: assert property (
      irq_req && !(wr_en && addr == pdt_pkg::ADDR_CONTROL) |=> irq_req)
      else $error("request lost");
endmodule // pdt_timer_chk

bind pdt_timer pdt_timer_chk i_chk (.clk(clk), .rst(rst), .addr(addr),
   .wr_en(wr_en), .wdata(wdata), .rd_en(rd_en), .rdata(rdata),
   .irq_req(irq_req), .irq_vector(irq_vector));

// *** dv/pdt_timer_tb.sv ***
`timescale 1ns/1ps
module pdt_timer_tb;
   logic       clk = 0, rst = 1, wr_en = 0, rd_en = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, p;
   logic       irq_req;
   logic [2:0] irq_vector;
   int         n_mismatch = 0, checked = 0, cyc = 0, n;

   pdt_timer i_dut (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
      .wdata(wdata), .rd_en(rd_en), .rdata(rdata), .irq_req(irq_req),
      .irq_vector(irq_vector));

   // Clock and hang guard; longest tap needs about 1.5k cycles a step
   initial forever #20 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         report_and_stop;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 0;
      #1;
   endtask

   // Data shows one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd_en <= 1;
      addr  <= a;
      @(posedge clk);
      rd_en <= 0;
      #1;
      chk(16'(rdata), 16'(exp));
   endtask

   // Back-to-back count reads, so every decrement is seen on its cycle
   task automatic start_rd;
      @(posedge clk);
      rd_en <= 1;
      addr  <= pdt_pkg::ADDR_COUNT;
      repeat (2) @(posedge clk);
      #1;
      v = rdata;
   endtask

   task automatic stop_rd;
      @(posedge clk);
      rd_en <= 0;
   endtask

   task automatic next_change;
      n = 0;
      while (rdata === v && n < 4000)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      v = rdata;
      // A count that never moves is a failure, not a silent pass
      if (n >= 4000)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, 4000);
      end
   endtask

   task automatic t_reset;
      rd(pdt_pkg::ADDR_COUNT, 8'hFF);
      rd(pdt_pkg::ADDR_PRESCALER, 8'h7F);
      rd(pdt_pkg::ADDR_CONTROL, 8'h00);
      chk(16'(irq_req), 16'h0000);
      chk(16'(irq_vector), 16'h0004);
      wr(pdt_pkg::ADDR_PRESCALER, 8'h10);
      rd(pdt_pkg::ADDR_PRESCALER, 8'h7F);
      rd(8'h10, 8'h00);
   endtask

   // Stop first so the divider restarts and no tick lands mid-check
   task automatic t_psc;
      wr(pdt_pkg::ADDR_CONTROL, 8'h20);
      wr(pdt_pkg::ADDR_CONTROL, 8'h28);
      wr(pdt_pkg::ADDR_PRESCALER, 8'hD5);
      rd(pdt_pkg::ADDR_PRESCALER, 8'h55);
      wr(pdt_pkg::ADDR_CONTROL, 8'h20);
      rd(pdt_pkg::ADDR_PRESCALER, 8'h7F);
   endtask

   task automatic t_write_zero;
      wr(pdt_pkg::ADDR_CONTROL, 8'h60);
      wr(pdt_pkg::ADDR_COUNT, 8'h00);
      chk(16'(irq_req), 16'h0001);
      rd(pdt_pkg::ADDR_CONTROL, 8'hE0);
      wr(pdt_pkg::ADDR_CONTROL, 8'h60);
      chk(16'(irq_req), 16'h0000);
      rd(pdt_pkg::ADDR_COUNT, 8'h00);
   endtask

   task automatic t_zero_irq;
      wr(pdt_pkg::ADDR_CONTROL, 8'h20);
      wr(pdt_pkg::ADDR_COUNT, 8'h02);
      wr(pdt_pkg::ADDR_CONTROL, 8'h68);
      start_rd;
      next_change;
      next_change;
      chk(16'(v), 16'h0000);
      chk(16'(irq_req), 16'h0001);
      next_change;
      chk(16'(v), 16'h00FF);
      chk(16'(irq_req), 16'h0001);
      stop_rd;
      wr(pdt_pkg::ADDR_CONTROL, 8'h28);
      chk(16'(irq_req), 16'h0000);
      wr(pdt_pkg::ADDR_CONTROL, 8'hA8);
      chk(16'(irq_req), 16'h0000);
      rd(pdt_pkg::ADDR_CONTROL, 8'hA8);
      wr(pdt_pkg::ADDR_CONTROL, 8'hE8);
      chk(16'(irq_req), 16'h0001);
   endtask

   // Reset in mid-count must restore every register and drop the request
   task automatic t_mid_reset;
      wr(pdt_pkg::ADDR_COUNT, 8'h00);
      chk(16'(irq_req), 16'h0001);
      @(posedge clk);
      rst <= 1;
      repeat (2) @(posedge clk);
      rst <= 0;
      #1;
      chk(16'(irq_req), 16'h0000);
      chk(16'(rdata), 16'h0000);
      rd(pdt_pkg::ADDR_COUNT, 8'hFF);
      rd(pdt_pkg::ADDR_PRESCALER, 8'h7F);
      rd(pdt_pkg::ADDR_CONTROL, 8'h00);
   endtask

   // Interval between two decrements is 12 times the tap division
   task automatic t_taps;
      for (int t = 0; t < 8; t++)
      begin
         wr(pdt_pkg::ADDR_CONTROL, {5'b00101, 3'(t)});
         start_rd;
         next_change;
         p = v;
         next_change;
         chk(16'(n), 16'(12 << t));
         chk(16'(v), 16'(8'(p - 8'h01)));
         stop_rd;
      end
   endtask

   task automatic report_and_stop;
      $display("Mismatches %0d, checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 0;
      t_reset;
      t_psc;
      t_write_zero;
      t_zero_irq;
      t_mid_reset;
      t_taps;
      report_and_stop;
   end
endmodule // pdt_timer_tb
